// File: ret_rot_exec.sv
// return and rotate instruction execution unit
// Operation
// - interrupt return pops stack, sets enable, two cycles
// - plain return pops stack, flags unchanged, two cycles
// - literal return loads working register, pops, two cycles
// - rotate left through carry, only carry changes
// - destination bit picks working or file register
`timescale 1ns/1ps
module ret_rot_exec (
   input  wire logic                            CORE_CLK,
   input  wire logic                            RESET_N,
   input  wire logic                            CLK_EN,
   input  wire ret_rot_pkg::op_e                OP_CODE,
   input  wire logic                            OP_VALID,
   input  wire logic [ret_rot_pkg::DATA_W-1:0]  LITERAL,
   input  wire logic [ret_rot_pkg::FADDR_W-1:0] FILE_ADDR,
   input  wire logic                            DEST_SEL,
   input  wire logic [ret_rot_pkg::DATA_W-1:0]  FILE_RDATA,
   input  wire logic [ret_rot_pkg::PC_W-1:0]    CALL_RET_ADDR,
   output logic                                 BUSY,
   output logic                                 DONE,
   output logic [ret_rot_pkg::PC_W-1:0]         PC_OUT,
   output logic                                 PC_LOAD,
   output logic [ret_rot_pkg::DATA_W-1:0]       W_OUT,
   output logic                                 CARRY_OUT,
   output logic [ret_rot_pkg::DATA_W-1:0]       ICR_OUT,
   output logic                                 FILE_WE,
   output logic [ret_rot_pkg::FADDR_W-1:0]      FILE_WADDR,
   output logic [ret_rot_pkg::DATA_W-1:0]       FILE_WDATA,
   output logic [ret_rot_pkg::SP_W-1:0]         SP_OUT
);
   import ret_rot_pkg::*;

   state_e               state_r, state_nxt;
   op_e                  op_r;
   logic [DATA_W-1:0]    lit_r;
   logic [SP_W-1:0]      sp_r;
   logic [PC_W-1:0]      tos_data;

   wire start      = CLK_EN && OP_VALID && (state_r == ST_IDLE);
   wire is_ret     = (OP_CODE == OP_RETFI) || (OP_CODE == OP_RET) || (OP_CODE == OP_RETLIT);
   wire start_ret  = start && is_ret;
   wire start_rot  = start && (OP_CODE == OP_ROTL);
   wire start_call = start && (OP_CODE == OP_CALL);
   // rotate: old carry into bit 0, old bit 7 out to carry
   wire [DATA_W-1:0] rot_res  = {FILE_RDATA[DATA_W-2:0], CARRY_OUT};
   wire              rot_cy   = FILE_RDATA[DATA_W-1];
   wire [SP_W-1:0]   sp_push  = sp_r + 4'h1;
   wire [SP_W-1:0]   sp_pop   = sp_r - 4'h1;

   // read port addressed by the pre-pop pointer, so the entry pointed to is delivered
   ret_stack_mem u_stack (
      .clk   (CORE_CLK),
      .ce    (CLK_EN),
      .we    (start_call),
      .waddr (sp_push),
      .wdata (CALL_RET_ADDR),
      .raddr (sp_r),
      .rdata (tos_data)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start_ret) begin
               state_nxt = ST_POP;
            end
         end
         ST_POP:  state_nxt = ST_DONE;
         ST_DONE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_r <= ST_IDLE;
         op_r    <= OP_NONE;
         lit_r   <= W_RESET;
      end else if (CLK_EN) begin
         state_r <= state_nxt;
         if (start_ret) begin
            op_r  <= OP_CODE;
            lit_r <= LITERAL;
         end
      end
   end

   // stack pointer: push on call, pop as return begins
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sp_r <= SP_RESET;
      end else if (CLK_EN) begin
         if (start_call) begin
            sp_r <= sp_push;
         end else if (start_ret) begin
            sp_r <= sp_pop;
         end
      end
   end

   // second cycle of a return: load pc and side effects
   wire fin = (state_r == ST_POP);

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         BUSY       <= 1'b0;
         DONE       <= 1'b0;
         PC_OUT     <= PC_RESET;
         PC_LOAD    <= 1'b0;
         W_OUT      <= W_RESET;
         CARRY_OUT  <= 1'b0;
         ICR_OUT    <= ICR_RESET;
         FILE_WE    <= 1'b0;
         FILE_WADDR <= '0;
         FILE_WDATA <= '0;
         SP_OUT     <= SP_RESET;
      end else if (CLK_EN) begin
         BUSY    <= start_ret;
         DONE    <= fin || start_rot;
         PC_LOAD <= fin;
         FILE_WE <= start_rot && DEST_SEL;
         SP_OUT  <= start_call ? sp_push : (start_ret ? sp_pop : sp_r);
         if (fin) begin
            PC_OUT <= tos_data;
            if (op_r == OP_RETFI) begin
               ICR_OUT[GIE_BIT] <= 1'b1;
            end
            if (op_r == OP_RETLIT) begin
               W_OUT <= lit_r;
            end
         end
         // plain return touches no flag
         if (start_rot) begin
            CARRY_OUT <= rot_cy;
            if (!DEST_SEL) begin
               W_OUT <= rot_res;
            end
            FILE_WADDR <= FILE_ADDR;
            FILE_WDATA <= rot_res;
         end
      end
   end
endmodule

// File: ret_rot_pkg.sv
// constants shared by the return and rotate execution unit
package ret_rot_pkg;
   localparam int DATA_W      = 8;
   localparam int PC_W        = 15;
   localparam int STACK_DEPTH = 16;
   localparam int SP_W        = 4;
   localparam int FADDR_W     = 7;
   localparam int GIE_BIT     = 7;
   localparam int RET_CYCLES  = 2;
   localparam logic [SP_W-1:0]    SP_RESET  = 4'hF;
   localparam logic [PC_W-1:0]    PC_RESET  = 15'h0000;
   localparam logic [DATA_W-1:0]  W_RESET   = 8'h00;
   localparam logic [DATA_W-1:0]  ICR_RESET = 8'h00;

   typedef enum logic [2:0] {
      OP_NONE   = 3'b000,
      OP_RETFI  = 3'b001,
      OP_RET    = 3'b010,
      OP_RETLIT = 3'b011,
      OP_ROTL   = 3'b100,
      OP_CALL   = 3'b101
   } op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_POP  = 2'b01,
      ST_DONE = 2'b10
   } state_e;
endpackage

// File: ret_stack_mem.sv
// call stack storage with registered read data
`timescale 1ns/1ps
module ret_stack_mem (
   input  wire logic                         clk,
   input  wire logic                         ce,
   input  wire logic                         we,
   input  wire logic [ret_rot_pkg::SP_W-1:0] waddr,
   input  wire logic [ret_rot_pkg::PC_W-1:0] wdata,
   input  wire logic [ret_rot_pkg::SP_W-1:0] raddr,
   output logic      [ret_rot_pkg::PC_W-1:0] rdata
);
   import ret_rot_pkg::*;
   logic [PC_W-1:0] mem [STACK_DEPTH];
   // no reset on storage: contents are undefined until pushed
   always_ff @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
endmodule

// File: ret_rot_exec_asserts.sv
// property checks for the return and rotate unit
`timescale 1ns/1ps
module ret_rot_exec_asserts
   import ret_rot_pkg::*;
(
   input logic CORE_CLK, RESET_N, CLK_EN, OP_VALID, DEST_SEL,
   input logic BUSY, DONE, PC_LOAD, CARRY_OUT,
   input logic FILE_WE,
   input op_e  OP_CODE,
   input logic [7:0] LITERAL, FILE_RDATA, W_OUT, ICR_OUT, FILE_WDATA,
   input logic [3:0] SP_OUT
);
// the pc-load cycle still belongs to the return, so nothing is taken there
wire go_w  = CLK_EN && OP_VALID && !BUSY && !PC_LOAD;
wire ret_w = go_w && OP_CODE inside {OP_RETFI, OP_RET, OP_RETLIT};
wire rot_w = go_w && OP_CODE == OP_ROTL;
default clocking @(posedge CORE_CLK); endclocking
default disable iff (!RESET_N);
ret_two_cycle_a: assert property (ret_w |=> BUSY ##1 PC_LOAD && DONE && !BUSY)
   else $error("return timing");
gie_set_a: assert property (ret_w && OP_CODE == OP_RETFI |-> ##2 ICR_OUT[GIE_BIT])
   else $error("enable not set");
lit_load_a: assert property (ret_w && OP_CODE == OP_RETLIT |-> ##2 W_OUT == $past(LITERAL, 2))
   else $error("literal lost");
sp_pop_a: assert property (ret_w |=> SP_OUT == $past(SP_OUT) - 4'h1)
   else $error("pointer not popped");
flag_keep_a: assert property (ret_w |-> ##2 CARRY_OUT == $past(CARRY_OUT, 2))
   else $error("carry changed");
rot_carry_a: assert property (rot_w |=> DONE && CARRY_OUT == $past(FILE_RDATA[7])
   && FILE_WDATA == {$past(FILE_RDATA[6:0]), $past(CARRY_OUT)}) else $error("rotate");
dest_sel_a: assert property (rot_w |=> FILE_WE == $past(DEST_SEL))
   else $error("destination");
endmodule
bind ret_rot_exec ret_rot_exec_asserts u_chk (.*);

// File: return_and_rotate_exec_tb.sv
// directed bench for the return and rotate unit
`timescale 1ns/1ps
module return_and_rotate_exec_tb;
import ret_rot_pkg::*;
logic CORE_CLK = 0, RESET_N = 0, CLK_EN = 1, OP_VALID = 0, DEST_SEL = 0;
op_e OP_CODE = OP_NONE;
logic [7:0] LITERAL = 0, FILE_RDATA = 0, W_OUT, ICR_OUT, FILE_WDATA;
logic [6:0] FILE_ADDR = 0, FILE_WADDR;
logic [14:0] CALL_RET_ADDR = 0, PC_OUT;
logic BUSY, DONE, PC_LOAD, CARRY_OUT, FILE_WE;
logic [3:0] SP_OUT, sp = 4'hF;
logic [14:0] stk [16];
logic c = 0;
int fails = 0, n_checks = 0;
ret_rot_exec dut (.*);
initial forever #4 CORE_CLK = ~CORE_CLK;
task chk(input logic [31:0] g, e);
   n_checks++;
   if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h want %h", $time, g, e);
   end
endtask
task close_out;
   $display("checks %0d fails %0d", n_checks, fails);
   if (fails == 0 && n_checks > 0) $display("Test passed");
   else $display("Test failed");
   $finish;
endtask
// rf keeps a call request up into the busy cycle, where it must be ignored
task go(op_e o, logic [14:0] a, logic rf);
   @(posedge CORE_CLK);
   OP_CODE <= o; OP_VALID <= 1; LITERAL <= a[7:0]; CALL_RET_ADDR <= a;
   FILE_RDATA <= a[7:0]; FILE_ADDR <= a[6:0]; DEST_SEL <= a[8];
   @(posedge CORE_CLK);
   if (rf) begin
      OP_CODE <= OP_CALL;
      @(posedge CORE_CLK);
   end
   OP_VALID <= 0;
endtask
task ret(op_e o, logic [7:0] k);
   go(o, {7'h0, k}, o == OP_RET);
   if (o != OP_RET) @(posedge CORE_CLK);
   #1;
   chk(PC_OUT, stk[sp]);
   chk({PC_LOAD, DONE, BUSY, CARRY_OUT}, {3'b110, c});
   sp--;
   chk(SP_OUT, sp);
   if (o == OP_RETFI) chk(ICR_OUT[7], 1);
   if (o == OP_RETLIT) chk(W_OUT, k);
endtask
task rot(logic [7:0] d, logic ds);
   go(OP_ROTL, {6'h0, ds, d}, 0);
   #1;
   chk({DONE, CARRY_OUT, FILE_WE}, {1'b1, d[7], ds});
   chk(ds ? FILE_WDATA : W_OUT, {d[6:0], c});
   if (ds) chk(FILE_WADDR, d[6:0]);
   c = d[7];
endtask
initial begin
   #100000;
   fails++;
   close_out;
end
initial begin
   repeat (16) @(posedge CORE_CLK);
   RESET_N <= 1;
   #1 chk({SP_OUT, W_OUT, ICR_OUT}, {4'hF, 16'h0});
   rot(8'hE6, 0);
   rot(8'h35, 1);
   rot(8'h01, 1);
   rot(8'h80, 0);
   for (int i = 1; i < 4; i++) begin
      go(OP_CALL, 15'h7AB0 + i[14:0], 0);
      sp++;
      stk[sp] = 15'h7AB0 + i[14:0];
      #1 chk(SP_OUT, sp);
   end
   ret(OP_RETLIT, 8'hFF);
   ret(OP_RET, 8'h00);
   ret(OP_RETFI, 8'h00);
   close_out;
end
endmodule
